// file: common/asp_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ASP_FORMAT_OFF 8'h07
`define ASP_OUTPUT_OFF 8'h08
`define ASP_LINK_OFF 8'h09

// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define ASP_FORMAT_RST 8'h30
`define ASP_OUTPUT_RST 8'h00
`define ASP_LINK_RST 8'h00
`define ASP_LINK_WMASK 8'hB0

// ----------------------------------------
// serial_format_config fields
// ----------------------------------------
`define ASP_FMT_HI 7
`define ASP_FMT_LO 6
`define ASP_WLEN_HI 5
`define ASP_WLEN_LO 4
`define ASP_FS_INV 3
`define ASP_BCK_INV 2
`define ASP_TX_EDGE 1
`define ASP_TX_FILL 0

// ----------------------------------------
// serial_output_config fields
// ----------------------------------------
`define ASP_LSB_HALF 7
`define ASP_KEEP_HI 6
`define ASP_KEEP_LO 5
`define ASP_OFS_HI 4
`define ASP_OFS_LO 0

// ----------------------------------------
// serial_link_config fields
// ----------------------------------------
`define ASP_CHAIN 7
`define ASP_ERRDET_OFF 5
`define ASP_RESUME_OFF 4

// ----------------------------------------
// timing
// ----------------------------------------
`define ASP_MCLK_MHZ 20
`define ASP_BUS_TIMEOUT_NS 3200
`define ASP_BUS_TIMEOUT_CYC ((`ASP_BUS_TIMEOUT_NS * `ASP_MCLK_MHZ) / 1000)

`endif

// file: common/asp_pkg.sv
// types shared by the audio serial port design
package asp_pkg;

  typedef enum logic [1:0] {
    ASP_FMT_TDM = 2'b00,
    ASP_FMT_I2S = 2'b01,
    ASP_FMT_LJ = 2'b10,
    ASP_FMT_RSVD = 2'b11
  } asp_format_t;

  typedef enum logic [1:0] {
    ASP_ST_IDLE = 2'b00,
    ASP_ST_RUN = 2'b01,
    ASP_ST_ERROR = 2'b10,
    ASP_ST_HALT = 2'b11
  } asp_state_t;

  typedef struct packed {
    logic [31:0] pri;
    logic [31:0] sec;
  } asp_sample_t;

  typedef struct packed {
    logic data;
    logic oe_n;
    logic keeper;
  } asp_pin_t;

endpackage

// file: rtl/asp_fifo.sv
// synchronous valid/ready fifo for the sample path
`timescale 1ns/1ps
module asp_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      if (pop) begin
        rd_q <= nxt(rd_q);
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// file: rtl/asp_port.sv
// audio serial output port: configuration registers and slot transmitter
`timescale 1ns/1ps
`include "asp_regs.svh"
module asp_port #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic s_valid,
  output logic s_ready,
  input wire asp_pkg::asp_sample_t s_data,
  input wire logic bclk,
  input wire logic frame_sync,
  input wire logic chain_in,
  output asp_pkg::asp_pin_t pri_pin,
  output asp_pkg::asp_pin_t sec_pin,
  output logic bus_error,
  output logic port_halted
);
  localparam logic [11:0] CNT_MAX = 12'hFFF;
  localparam logic [7:0] TIMEOUT = 8'(`ASP_BUS_TIMEOUT_CYC);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] fmt_cfg_q;
  logic [7:0] out_cfg_q;
  logic [7:0] link_cfg_q;
  logic cfg_write;

  assign cfg_write = reg_wr && (reg_addr == `ASP_FORMAT_OFF ||
    reg_addr == `ASP_OUTPUT_OFF || reg_addr == `ASP_LINK_OFF);

  always_ff @(posedge mclk) begin
    if (srst) begin
      fmt_cfg_q <= `ASP_FORMAT_RST;
      out_cfg_q <= `ASP_OUTPUT_RST;
      link_cfg_q <= `ASP_LINK_RST;
    end else if (reg_wr) begin
      if (reg_addr == `ASP_FORMAT_OFF) begin
        fmt_cfg_q <= reg_wdata;
      end
      if (reg_addr == `ASP_OUTPUT_OFF) begin
        out_cfg_q <= reg_wdata;
      end
      if (reg_addr == `ASP_LINK_OFF) begin
        link_cfg_q <= reg_wdata & `ASP_LINK_WMASK;
      end
    end
  end

  // reserved link bits are masked on write, so they read zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ASP_FORMAT_OFF: reg_rdata <= fmt_cfg_q;
        `ASP_OUTPUT_OFF: reg_rdata <= out_cfg_q;
        `ASP_LINK_OFF: reg_rdata <= link_cfg_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  asp_pkg::asp_format_t fmt;
  logic [1:0] keep_mode;
  logic [4:0] offset;
  logic tx_edge;
  logic fill_z;
  logic lsb_half;
  logic chain;
  logic det_off;
  logic resume_off;

  assign fmt = asp_pkg::asp_format_t'(fmt_cfg_q[`ASP_FMT_HI:`ASP_FMT_LO]);
  assign keep_mode = out_cfg_q[`ASP_KEEP_HI:`ASP_KEEP_LO];
  assign offset = out_cfg_q[`ASP_OFS_HI:`ASP_OFS_LO];
  assign tx_edge = fmt_cfg_q[`ASP_TX_EDGE];
  assign fill_z = fmt_cfg_q[`ASP_TX_FILL];
  assign lsb_half = out_cfg_q[`ASP_LSB_HALF];
  assign chain = link_cfg_q[`ASP_CHAIN];
  assign det_off = link_cfg_q[`ASP_ERRDET_OFF];
  assign resume_off = link_cfg_q[`ASP_RESUME_OFF];

  function automatic logic [5:0] slot_len(input logic [1:0] code);
    unique case (code)
      2'b00: slot_len = 6'd16;
      2'b01: slot_len = 6'd20;
      2'b10: slot_len = 6'd24;
      2'b11: slot_len = 6'd32;
    endcase
  endfunction

  // ----------------------------------------
  // link input synchronisers
  // ----------------------------------------
  logic bclk_m_q, bclk_s_q, fs_m_q, fs_s_q, ch_m_q, ch_s_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      bclk_m_q <= 1'b0;
      bclk_s_q <= 1'b0;
      fs_m_q <= 1'b0;
      fs_s_q <= 1'b0;
      ch_m_q <= 1'b0;
      ch_s_q <= 1'b0;
    end else begin
      bclk_m_q <= bclk;
      bclk_s_q <= bclk_m_q;
      fs_m_q <= frame_sync;
      fs_s_q <= fs_m_q;
      ch_m_q <= chain_in;
      ch_s_q <= ch_m_q;
    end
  end

  // ----------------------------------------
  // edge and frame detection
  // ----------------------------------------
  logic bclk_eff, bclk_p_q, rise, fall, launch, mid;
  logic fs_eff, fs_p_q, frame_start, right_start;

  // polarity inversions; I2S left half is sync low
  assign bclk_eff = bclk_s_q ^ fmt_cfg_q[`ASP_BCK_INV];
  assign fs_eff = fs_s_q ^ fmt_cfg_q[`ASP_FS_INV] ^
    (fmt == asp_pkg::ASP_FMT_I2S);
  assign rise = bclk_eff & ~bclk_p_q;
  assign fall = ~bclk_eff & bclk_p_q;
  // edge bit moves launch to the following edge
  assign launch = tx_edge ? rise : fall;
  assign mid = tx_edge ? fall : rise;
  // frame begins on sync edge seen at bit clock rise
  assign frame_start = rise & fs_eff & ~fs_p_q;
  assign right_start = rise & ~fs_eff & fs_p_q &
    (fmt != asp_pkg::ASP_FMT_TDM);

  always_ff @(posedge mclk) begin
    if (srst) begin
      bclk_p_q <= 1'b0;
      fs_p_q <= 1'b0;
    end else begin
      bclk_p_q <= bclk_eff;
      if (rise) begin
        fs_p_q <= fs_eff;
      end
    end
  end

  // ----------------------------------------
  // bit position counter
  // ----------------------------------------
  logic [11:0] cnt_q, pos0, rel, len12;
  logic active, is_msb, is_lsb;

  // count bit clocks from each frame start and, outside TDM, each right-half start
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= CNT_MAX;
    end else if (frame_start || right_start) begin
      cnt_q <= 12'h000;
    end else if (rise && cnt_q != CNT_MAX) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // offset applies to slot 0 of both halves
  assign pos0 = 12'(offset) + ((fmt == asp_pkg::ASP_FMT_I2S) ?
    12'h001 : 12'h000);
  assign len12 = 12'(slot_len(fmt_cfg_q[`ASP_WLEN_HI:`ASP_WLEN_LO]));
  assign rel = cnt_q - pos0;
  assign active = (cnt_q >= pos0) && (rel < len12) && (cnt_q != CNT_MAX);
  assign is_msb = active && (rel == 12'h000);
  assign is_lsb = active && (rel == len12 - 12'h001);

  // ----------------------------------------
  // error detection and run state
  // ----------------------------------------
  asp_pkg::asp_state_t state_q;
  logic [7:0] idle_q;
  logic [11:0] flen_q, last_len_q;
  logic have_len_q, mismatch, timeout, running;

  assign running = (state_q == asp_pkg::ASP_ST_RUN);
  assign mismatch = frame_start && have_len_q && (flen_q != last_len_q);
  assign timeout = (idle_q == TIMEOUT);

  // bit clock watchdog; link clock may rest before the first frame
  always_ff @(posedge mclk) begin
    if (srst || rise) begin
      idle_q <= 8'h00;
    end else if (!timeout) begin
      idle_q <= idle_q + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst || timeout) begin
      flen_q <= 12'h000;
      last_len_q <= 12'h000;
      have_len_q <= 1'b0;
    end else if (frame_start) begin
      flen_q <= 12'h001;
      last_len_q <= flen_q;
      have_len_q <= (flen_q != 12'h000);
    end else if (rise && flen_q != CNT_MAX) begin
      flen_q <= flen_q + 12'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= asp_pkg::ASP_ST_IDLE;
    end else begin
      unique case (state_q)
        asp_pkg::ASP_ST_IDLE: begin
          if (frame_start) begin
            state_q <= asp_pkg::ASP_ST_RUN;
          end
        end
        asp_pkg::ASP_ST_RUN: begin
          // errors only while detection is enabled
          if (!det_off && (mismatch || timeout)) begin
            state_q <= asp_pkg::ASP_ST_ERROR;
          end
        end
        asp_pkg::ASP_ST_ERROR: begin
          // two equal frames count as recovery
          if (frame_start && have_len_q && !mismatch) begin
            state_q <= resume_off ? asp_pkg::ASP_ST_HALT :
              asp_pkg::ASP_ST_RUN;
          end
        end
        asp_pkg::ASP_ST_HALT: begin
          // held down until the host reconfigures
          if (cfg_write) begin
            state_q <= asp_pkg::ASP_ST_IDLE;
          end
        end
      endcase
    end
  end

  assign bus_error = (state_q == asp_pkg::ASP_ST_ERROR) ||
    (state_q == asp_pkg::ASP_ST_HALT);
  assign port_halted = !running;

  // ----------------------------------------
  // sample fifo and word hold
  // ----------------------------------------
  asp_pkg::asp_sample_t fifo_data, word_q, word_src;
  logic fifo_valid, pop;

  assign pop = fall && is_msb && running;

  asp_fifo #(
    .WIDTH($bits(asp_pkg::asp_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(s_valid),
    .in_ready(s_ready),
    .in_data(s_data),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // underrun sends a zero word rather than stalling the link
  assign word_src = !is_msb ? word_q : (fifo_valid ? fifo_data : '0);

  always_ff @(posedge mclk) begin
    if (srst) begin
      word_q <= '0;
    end else if (pop) begin
      word_q <= word_src;
    end
  end

  // ----------------------------------------
  // bit selection for both data pins
  // ----------------------------------------
  logic [4:0] bit_idx;
  logic pri_now, sec_now, pri_drv, sec_drv, lsb_now;
  logic pri_pend_q, sec_pend_q, pri_dpend_q, sec_dpend_q, lsb_pend_q;

  // words are msb-justified, short slots use the top bits
  assign bit_idx = 5'd31 - rel[4:0];
  // daisy chain passes upstream data in unused cycles
  assign pri_now = active ? word_src.pri[bit_idx] : (chain & ch_s_q);
  assign sec_now = active ? word_src.sec[bit_idx] : 1'b0;
  assign pri_drv = running && (active || chain || !fill_z);
  // fill rule alone on the secondary pin; chain does not drive it
  assign sec_drv = running && (active || !fill_z);
  assign lsb_now = running && is_lsb;

  // bit is chosen at the fall; delayed launch replays it at the rise
  always_ff @(posedge mclk) begin
    if (srst) begin
      pri_pend_q <= 1'b0;
      sec_pend_q <= 1'b0;
      pri_dpend_q <= 1'b0;
      sec_dpend_q <= 1'b0;
      lsb_pend_q <= 1'b0;
    end else if (fall) begin
      pri_pend_q <= pri_now;
      sec_pend_q <= sec_now;
      pri_dpend_q <= pri_drv;
      sec_dpend_q <= sec_drv;
      lsb_pend_q <= lsb_now;
    end
  end

  // ----------------------------------------
  // pin drive, last bit and keeper
  // ----------------------------------------
  logic pri_d_q, sec_d_q, pri_en_q, sec_en_q, new_lsb;
  logic [1:0] lsb_ph_q;
  logic float_half, keep_on;

  assign new_lsb = tx_edge ? lsb_pend_q : lsb_now;

  // launch register fed from fall or delayed copy
  always_ff @(posedge mclk) begin
    if (srst) begin
      pri_d_q <= 1'b0;
      sec_d_q <= 1'b0;
      pri_en_q <= 1'b0;
      sec_en_q <= 1'b0;
    end else if (launch) begin
      pri_d_q <= tx_edge ? pri_pend_q : pri_now;
      sec_d_q <= tx_edge ? sec_pend_q : sec_now;
      pri_en_q <= tx_edge ? pri_dpend_q : pri_drv;
      sec_en_q <= tx_edge ? sec_dpend_q : sec_drv;
    end
  end

  // lsb phase: 1 first half, 2 second half, 3 half after
  always_ff @(posedge mclk) begin
    if (srst) begin
      lsb_ph_q <= 2'd0;
    end else if (launch) begin
      lsb_ph_q <= new_lsb ? 2'd1 : ((lsb_ph_q == 2'd2) ? 2'd3 : 2'd0);
    end else if (mid) begin
      lsb_ph_q <= (lsb_ph_q == 2'd1) ? 2'd2 : 2'd0;
    end
  end

  // optional float in the second half of the lsb
  assign float_half = lsb_half && (lsb_ph_q == 2'd2);

  always_comb begin
    unique case (keep_mode)
      2'd0: keep_on = 1'b0;
      2'd1: keep_on = 1'b1;
      2'd2: keep_on = (lsb_ph_q == 2'd1) || (lsb_ph_q == 2'd2);
      2'd3: keep_on = (lsb_ph_q != 2'd0);
    endcase
  end

  // one keeper and lsb float control serves both pins
  // leaving run floats at once; a stopped bit clock brings no launch
  assign pri_pin.data = pri_d_q;
  assign pri_pin.oe_n = !pri_en_q || float_half || !running;
  assign pri_pin.keeper = keep_on;
  assign sec_pin.data = sec_d_q;
  assign sec_pin.oe_n = !sec_en_q || float_half || !running;
  assign sec_pin.keeper = keep_on;
endmodule

// file: bench/asp_host_model.sv
// host audio port model: bit clock within bursts and frame sync
`timescale 1ns/1ps
module asp_host_model (
  input wire logic run,
  input wire logic [7:0] flen,
  input wire logic [1:0] fmt,
  input wire logic fs_inv,
  input wire logic bck_inv,
  output logic bclk,
  output logic frame_sync,
  output logic eck,
  output int pos
);
  int np;
  int len;
  logic half;
  assign bclk = eck ^ bck_inv;
  initial begin
    eck = 1'b0;
    frame_sync = 1'b0;
    len = 64;
    pos = 63;
    #7;
    forever begin
      if (!run) begin
        // clock stands still outside bursts
        #200;
      end else begin
        np = (pos + 1 >= len) ? 0 : pos + 1;
        if (np == 0) begin
          len = flen;
        end
        half = (np >= len / 2);
        frame_sync = fs_inv ^ (fmt == 2'h0 ? np == 0 : half == (fmt == 2'h1));
        #200;
        pos = np;
        eck = 1'b1;
        #200;
        eck = 1'b0;
      end
    end
  end
endmodule

// file: bench/asp_port_checker.sv
// concurrent checks on the audio serial port boundary
`timescale 1ns/1ps
module asp_port_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic s_ready,
  input wire logic bclk,
  input wire asp_pkg::asp_pin_t pri_pin,
  input wire asp_pkg::asp_pin_t sec_pin,
  input wire logic bus_error,
  input wire logic port_halted
);
  logic [1:0] keep_q;
  logic det_off_q;
  logic bclk_q;
  logic [6:0] idle_q;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (srst);
  always_ff @(posedge mclk) begin
    if (srst) begin
      keep_q <= 2'h0;
      det_off_q <= 1'b0;
    end else if (reg_wr && reg_addr == 8'h08) begin
      keep_q <= reg_wdata[6:5];
    end else if (reg_wr && reg_addr == 8'h09) begin
      det_off_q <= reg_wdata[5];
    end
  end
  // raw bit clock age, saturating so it never wraps back
  always_ff @(posedge mclk) begin
    bclk_q <= bclk;
    if (srst || bclk != bclk_q) begin
      idle_q <= 7'h00;
    end else if (idle_q != 7'h7F) begin
      idle_q <= idle_q + 7'h01;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rst_levels_a:
    assert property ($fell(srst) |-> port_halted && !bus_error
      && pri_pin.oe_n && sec_pin.oe_n) else $error("bad reset levels");
  rst_format_a:
    assert property ($fell(srst) && reg_rd && reg_addr == 8'h07
      |=> reg_rdata == 8'h30) else $error("format reset value wrong");
  link_rsvd_a:
    assert property (reg_rd && reg_addr == 8'h09
      |=> (reg_rdata & 8'h4F) == 8'h00) else $error("reserved bits set");
  unmapped_zero_a:
    assert property (reg_rd && reg_addr > 8'h09 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  error_halts_a:
    assert property (bus_error |-> port_halted)
    else $error("error without halt");
  halt_float_a:
    assert property (port_halted [*3] |-> pri_pin.oe_n && sec_pin.oe_n)
    else $error("pins driven while halted");
  halt_no_pop_a:
    assert property (port_halted && !s_ready |=> !s_ready)
    else $error("fifo popped while halted");
  keeper_fixed_a:
    assert property (!keep_q[1] [*3] |-> pri_pin.keeper == keep_q[0])
    else $error("fixed keeper mode wrong");
  keeper_pair_a:
    assert property (pri_pin.keeper == sec_pin.keeper)
    else $error("keepers differ");
  bclk_timeout_a:
    assert property (idle_q == 7'h64 && !det_off_q |-> port_halted)
    else $error("stalled bit clock missed");
endmodule
bind asp_port asp_port_checker chk_i (
  .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .s_ready(s_ready), .bclk(bclk), .pri_pin(pri_pin), .sec_pin(sec_pin),
  .bus_error(bus_error), .port_halted(port_halted)
);

// file: bench/audio_serial_port_config_bench.sv
// self-checking bench for the audio serial port
`timescale 1ns/1ps
module audio_serial_port_config_bench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic s_valid = 1'b0;
  logic s_ready;
  asp_pkg::asp_sample_t s_data = 64'hA5C3_9617_3C5A_E18D;
  logic chain_in = 1'b1;
  asp_pkg::asp_pin_t pri_pin;
  asp_pkg::asp_pin_t sec_pin;
  logic bus_error;
  logic port_halted;
  logic bclk;
  logic frame_sync;
  logic eck;
  int pos;
  logic run = 1'b0;
  logic [7:0] flen = 8'h40;
  logic [1:0] fmt = 2'h0;
  logic fs_inv = 1'b0;
  logic bck_inv = 1'b0;
  logic chn = 1'b0;
  logic [31:0] wp = 32'hA5C3_9617;
  logic [31:0] ws = 32'h3C5A_E18D;
  logic [7:0] rv [4] = '{8'h0F, 8'h50, 8'hA5, 8'h30};
  logic [7:0] c0v [6] = '{8'h30, 8'h01, 8'h1E, 8'h20, 8'hA0, 8'h40};
  logic [7:0] c1v [6] = '{8'h00, 8'h20, 8'h43, 8'hFF, 8'h05, 8'h00};
  int fails = 0;
  int compares = 0;

  always #25 mclk = ~mclk;

  asp_port #(.FIFO_DEPTH(8)) uut (
    .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .s_valid(s_valid), .s_ready(s_ready), .s_data(s_data), .bclk(bclk),
    .frame_sync(frame_sync), .chain_in(chain_in), .pri_pin(pri_pin),
    .sec_pin(sec_pin), .bus_error(bus_error), .port_halted(port_halted)
  );
  asp_host_model host (
    .run(run), .flen(flen), .fmt(fmt), .fs_inv(fs_inv),
    .bck_inv(bck_inv), .bclk(bclk), .frame_sync(frame_sync), .eck(eck),
    .pos(pos)
  );
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
    wr(8'h07, c0);
    wr(8'h08, c1);
    fmt = c0[7:6];
    fs_inv = c0[3];
    bck_inv = c0[2];
  endtask
  // waits for the start rise; gives up after 300 bit clock rises without one, a stopped clock still blocks
  task automatic frame_start();
    int n;
    n = 0;
    do begin
      @(posedge eck);
      n++;
      if (n > 300) begin
        fails++;
        end_of_test();
      end
    end while (pos != 0);
  endtask
  // synchroniser latency is about three mclk, eight gives margin
  task automatic starts(input int n);
    repeat (n) frame_start();
    repeat (8) @(negedge mclk);
  endtask
  task automatic frame_chk(input logic [7:0] c0, input logic [7:0] c1);
    int len;
    int ofs;
    int p;
    logic [4:0] e;
    logic [4:0] m;
    logic k;
    len = (c0[5:4] == 2'h3) ? 32 : 16 + 4 * c0[5:4];
    ofs = c1[4:0] + (c0[7:6] == 2'h1);
    frame_start();
    for (int i = 1; i <= len + ofs + 2; i++) begin
      @(posedge eck);
      if (c0[1]) @(negedge eck);
      p = i - 1 - ofs;
      k = c1[6:5] == 2'h1 || (c1[6] && p == len - 1)
        || (c1[6:5] == 2'h3 && p == len);
      if (p >= 0 && p < len) begin
        e = {wp[31-p], 1'b0, ws[31-p], 1'b0, k};
        m = 5'h1F;
      end else begin
        e = {chain_in & chn, c0[0], 1'b0, c0[0], k};
        m = c0[0] ? 5'h0B : 5'h1F;
      end
      chk({pri_pin.data, pri_pin.oe_n, sec_pin.data, sec_pin.oe_n,
        pri_pin.keeper} & m, e & m);
      if (p == len - 1 && !c0[1]) begin
        #175;
        chk(pri_pin.oe_n, c1[7]);
      end
    end
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    reg_addr = 8'h07;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk(reg_rdata, 8'h30);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    rd(8'h0A, 8'h00);
    foreach (rv[j]) begin
      wr(8'h07, rv[j]);
      rd(8'h07, rv[j]);
    end
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'hFF);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'hB0);
    s_valid = 1'b1;
    repeat (12) @(negedge mclk);
    chk(s_ready, 1'b0);
    wr(8'h09, 8'h20);
    run = 1'b1;
    foreach (c0v[j]) begin
      cfg(c0v[j], c1v[j]);
      starts(2);
      frame_chk(c0v[j], c1v[j]);
    end
    cfg(8'h30, 8'h00);
    wr(8'h09, 8'hA0);
    chn = 1'b1;
    starts(2);
    frame_chk(8'h30, 8'h00);
    wr(8'h09, 8'h20);
    chn = 1'b0;
    s_valid = 1'b0;
    wp = 32'h0;
    ws = 32'h0;
    starts(10);
    frame_chk(8'h30, 8'h00);
    wr(8'h09, 8'h00);
    starts(3);
    chk({bus_error, port_halted}, 2'h0);
    flen = 8'h30;
    starts(2);
    chk(bus_error, 1'b1);
    starts(2);
    chk({bus_error, port_halted}, 2'h0);
    wr(8'h09, 8'h10);
    flen = 8'h40;
    starts(4);
    chk({bus_error, port_halted}, 2'h3);
    wr(8'h09, 8'h10);
    starts(2);
    chk({bus_error, port_halted}, 2'h0);
    run = 1'b0;
    repeat (120) @(negedge mclk);
    chk(bus_error, 1'b1);
    wr(8'h09, 8'h00);
    run = 1'b1;
    starts(4);
    chk(port_halted, 1'b0);
    wr(8'h09, 8'h20);
    run = 1'b0;
    repeat (120) @(negedge mclk);
    chk(bus_error, 1'b0);
    end_of_test();
  end
endmodule
